// ### hdl/epc_checker.sv
// enclave system call decode, fault check and dispatch
// ---------------------------------------------------------------
// Overview of operation
// - recognise 0F 01 CF with no explicit operands, implicit registers only
// - leaf taken from accumulator; other registers belong to the leaf flow
// - upper 32 accumulator bits ignored in 64-bit mode
// - invalid opcode if protection off, virtual-8086, or system management mode
// - invalid opcode when privilege level above zero
// - invalid opcode when base enclave feature bit is zero
// - invalid opcode on lock, operand-size, repeat or vector prefix
// - general protection unless feature lock and enclave enable both set
// - general protection on undefined leaf index
// - general protection when paging disabled
// - general protection outside 64-bit mode on expand-down data segment
// - guest exit via bitmap bit of leaf; indexes above 62 use bit 63
// - order: transaction abort, opcode, privilege, exit, protection, segment
// - 32-bit width outside 64-bit mode, 64-bit inside it
// - segment and address-size prefixes ignored; extension prefix in 64-bit mode
// - unrecognised in real and virtual-8086 modes
// - compatibility mode uses protected mode faults
// - tracking leaves exclusive against each other, page conflict on collision
// - tracking collision exit carries tracking conflict qualification
// - dispatch to leaf flow only after all checks pass
// ---------------------------------------------------------------
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
module epc_checker
  import epc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire epc_insn_t insn,
  input wire epc_ctx_t ctx,
  input wire logic track_busy,
  output logic done_valid,
  output epc_out_t done,
  output logic track_hold
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_track(input logic [31:0] leaf);
    is_track = (leaf == LEAF_TRACK) || (leaf == LEAF_TRACKC);
  endfunction : is_track

  function automatic logic [31:0] leaf_of(input logic [63:0] rax);
    leaf_of = rax[31:0];
  endfunction : leaf_of

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  epc_state_t state_q;
  epc_insn_t insn_q;
  epc_ctx_t ctx_q;
  epc_out_t out_q;
  epc_out_t out_d;
  logic [31:0] ctrl_q;
  logic [31:0] count_q;
  logic track_hold_q;
  logic wide;
  logic [31:0] leaf;
  logic bm_hit;

  assign issue_ready = (state_q == ST_IDLE);
  assign done_valid = (state_q == ST_DONE);
  assign done = out_q;
  assign track_hold = track_hold_q;

  // ---------------------------------------------------------------
  // capture and sequence
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (issue_valid) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state_q <= ST_DONE;
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_q <= '0;
      ctx_q <= '0;
    end else if (issue_valid && state_q == ST_IDLE) begin
      insn_q <= insn;
      ctx_q <= ctx;
    end
  end

  // ---------------------------------------------------------------
  // ordered checks
  // ---------------------------------------------------------------
  assign wide = ctx_q.long_mode_active && ctx_q.cs_long;
  assign leaf = leaf_of(insn_q.rax);
  assign bm_hit = (leaf > BITMAP_LAST_IDX) ? ctx_q.exit_bitmap[BITMAP_TOP]
                : ctx_q.exit_bitmap[leaf[5:0]];

  always_comb begin
    out_d.code = ERR_ZERO;
    out_d.leaf = leaf;
    out_d.wide = wide;
    // segment and address-size prefixes never looked at
    if (ctx_q.transactional_execution) begin
      out_d.res = RES_TSX_ABORT;
    end else if (!(insn_q.b0 == OPC_ESC && insn_q.b1 == OPC_GRP && insn_q.b2 == OPC_CALL)) begin
      out_d.res = RES_UD;
    end else if (!ctx_q.protection_enable_bit || ctx_q.virtual8086_flag
                 || ctx_q.system_management_mode
                 || !ctx_q.base_enclave_feature_bit) begin
      out_d.res = RES_UD;
    end else if (insn_q.pfx_lock || insn_q.pfx_osize || insn_q.pfx_rep
                 || insn_q.pfx_vex) begin
      out_d.res = RES_UD;
    end else if (ctx_q.current_privilege_level != 2'b00) begin
      out_d.res = RES_UD;
    end else if (ctx_q.virtualization_operation && ctx_q.exiting_control && bm_hit) begin
      out_d.res = RES_VMEXIT;
    end else if (!ctx_q.feature_lock_register[FEAT_LOCK_BIT]
                 || !ctx_q.feature_lock_register[FEAT_ENCL_BIT]) begin
      out_d.res = RES_GP;
    end else if (leaf >= LEAF_COUNT) begin
      out_d.res = RES_GP;
    end else if (!ctx_q.paging_enable_bit) begin
      out_d.res = RES_GP;
    end else if (!wide && ctx_q.ds_expand_down) begin
      out_d.res = RES_GP;
    end else if (is_track(leaf) && (track_busy || track_hold_q)
                 && !ctrl_q[CTRL_TRK_MASK_BIT]) begin
      out_d.res = RES_CONFLICT;
      if (ctx_q.virtualization_operation) begin
        out_d.code = QUAL_TRK_CONFLICT;
      end
    end else begin
      out_d.res = RES_DISPATCH;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
    end else if (state_q == ST_CHECK) begin
      out_q <= out_d;
    end
  end

  // tracking leaf holds control structure from dispatch until the check cycle of the next instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_hold_q <= 1'b0;
    end else if (state_q == ST_CHECK) begin
      track_hold_q <= (out_d.res == RES_DISPATCH) && is_track(leaf);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (state_q == ST_CHECK && out_d.res == RES_DISPATCH) begin
      count_q <= count_q + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic wr_en;
  logic known;

  assign pready = 1'b1;
  assign known = (paddr == REG_CTRL) || (paddr == REG_STATUS)
               || (paddr == REG_LEAF) || (paddr == REG_COUNT);
  assign pslverr = psel && penable && !known;
  assign wr_en = psel && penable && pwrite && (paddr == REG_CTRL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_en) begin
      ctrl_q <= {31'h00000000, pwdata[CTRL_TRK_MASK_BIT]};
    end
  end

  always_comb begin
    case (paddr)
      REG_CTRL: prdata = ctrl_q;
      REG_STATUS: prdata = {11'h000, out_q.code, track_hold_q, out_q.res};
      REG_LEAF: prdata = out_q.leaf;
      REG_COUNT: prdata = count_q;
      default: prdata = 32'h00000000;
    endcase
  end

endmodule : epc_checker

// ### hdl/epc_pkg.sv
// package of constants and carriers for the enclave call checker
package epc_pkg;

  // ---------------------------------------------------------------
  // opcode and leaf constants
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ESC = 8'h0F;
  localparam logic [7:0] OPC_GRP = 8'h01;
  localparam logic [7:0] OPC_CALL = 8'hCF;
  localparam int LEAF_W = 32;
  localparam logic [31:0] LEAF_COUNT = 32'h00000013;
  localparam logic [31:0] LEAF_TRACK = 32'h0000000C;
  localparam logic [31:0] LEAF_TRACKC = 32'h00000011;
  localparam logic [31:0] BITMAP_LAST_IDX = 32'h0000003E;
  localparam int BITMAP_TOP = 63;
  localparam int FEAT_LOCK_BIT = 0;
  localparam int FEAT_ENCL_BIT = 1;
  localparam int BASE_FEAT_BIT = 0;

  // ---------------------------------------------------------------
  // register offsets (apb byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LEAF = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int CTRL_TRK_MASK_BIT = 0;

  // ---------------------------------------------------------------
  // result codes and carriers
  // ---------------------------------------------------------------
  localparam logic [15:0] ERR_ZERO = 16'h0000;
  localparam logic [15:0] QUAL_TRK_CONFLICT = 16'h0001;

  typedef enum logic [3:0] {
    RES_NONE = 4'h0,
    RES_TSX_ABORT = 4'h1,
    RES_UD = 4'h2,
    RES_VMEXIT = 4'h3,
    RES_GP = 4'h4,
    RES_CONFLICT = 4'h5,
    RES_DISPATCH = 4'h6
  } epc_res_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_DONE = 3'b100
  } epc_state_t;

  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic pfx_lock;
    logic pfx_osize;
    logic pfx_rep;
    logic pfx_vex;
    logic pfx_seg;
    logic pfx_asize;
    logic pfx_rex;
    logic [63:0] rax;
  } epc_insn_t;

  typedef struct packed {
    logic protection_enable_bit;
    logic paging_enable_bit;
    logic virtual8086_flag;
    logic system_management_mode;
    logic [1:0] current_privilege_level;
    logic long_mode_active;
    logic cs_long;
    logic ds_expand_down;
    logic transactional_execution;
    logic base_enclave_feature_bit;
    logic [7:0] feature_lock_register;
    logic virtualization_operation;
    logic exiting_control;
    logic [63:0] exit_bitmap;
  } epc_ctx_t;

  typedef struct packed {
    epc_res_t res;
    logic [15:0] code;
    logic [31:0] leaf;
    logic wide;
  } epc_out_t;

endpackage : epc_pkg

// ### verification/epc_checker_asserts.sv
// assertions on the enclave call checker ports
module epc_checker_asserts
  import epc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire epc_insn_t insn,
  input wire epc_ctx_t ctx,
  input wire logic done_valid,
  input wire epc_out_t done
);
  wire logic tk = issue_valid && issue_ready;
  wire logic ok = tk && !ctx.transactional_execution;
  wire logic md = !ctx.protection_enable_bit || ctx.virtual8086_flag;
  wire logic pf = insn.pfx_lock || insn.pfx_osize || insn.pfx_rep || insn.pfx_vex;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_done_delay: assert property (tk |=> !done_valid ##1 done_valid)
    else $error("result not two cycles after take");
  a_take_refuse: assert property (tk |=> !issue_ready [*2])
    else $error("issue taken while busy");
  a_abort_first: assert property (tk && ctx.transactional_execution |-> ##2 done.res == RES_TSX_ABORT)
    else $error("transaction abort not first");
  a_mode_ud: assert property (ok && (md || ctx.system_management_mode) |-> ##2 done.res == RES_UD)
    else $error("mode fault missing");
  a_prefix_ud: assert property (ok && pf |-> ##2 done.res == RES_UD)
    else $error("prefix fault missing");
  a_priv_ud: assert property (ok && ctx.current_privilege_level != 2'h0 |-> ##2 done.res == RES_UD)
    else $error("privilege fault missing");
  a_gp_zero: assert property (done_valid && done.res == RES_GP |-> done.code == ERR_ZERO)
    else $error("protection code not zero");
  a_leaf_low: assert property (done_valid && done.res == RES_DISPATCH |-> done.leaf == $past(insn.rax[31:0], 2))
    else $error("leaf not low accumulator bits");
endmodule : epc_checker_asserts
bind epc_checker epc_checker_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .issue_valid(issue_valid), .issue_ready(issue_ready),
  .insn(insn), .ctx(ctx), .done_valid(done_valid), .done(done));

// ### verification/privileged_enclave_call_checker_bench.sv
// self-checking bench for the enclave call checker
module privileged_enclave_call_checker_bench
  import epc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, issue_valid = 0;
  logic track_busy = 0, pready, pslverr, issue_ready, done_valid, track_hold, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  epc_insn_t insn = '0, ni;
  epc_ctx_t ctx = '0, nc;
  epc_out_t done;
  int mismatches = 0, cmp_count = 0, nd = 0;
  always #25 pclk = ~pclk;
  epc_checker uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .issue_valid(issue_valid), .issue_ready(issue_ready), .insn(insn),
    .ctx(ctx), .track_busy(track_busy), .done_valid(done_valid), .done(done),
    .track_hold(track_hold));
  task automatic chk(string n, logic [63:0] s, logic [63:0] x);
    cmp_count++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", n, x, s);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic base();
    ni = '0;
    {ni.b0, ni.b1, ni.b2} = {OPC_ESC, OPC_GRP, OPC_CALL};
    nc = '0;
    {nc.protection_enable_bit, nc.paging_enable_bit} = 2'b11;
    {nc.long_mode_active, nc.cs_long, nc.base_enclave_feature_bit} = 3'b111;
    nc.feature_lock_register = 8'h03;
  endtask : base
  task automatic run(epc_res_t r);
    @(posedge pclk);
    {insn, ctx, issue_valid} <= {ni, nc, 1'b1};
    @(negedge pclk);
    while (issue_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    issue_valid <= 1'b0;
    for (int n = 0; n < 4 && done_valid !== 1'b1; n++) @(negedge pclk);
    chk("done_valid", done_valid, 1);
    chk("res", done.res, r);
    if (r == RES_DISPATCH) nd++;
  endtask : run
  task automatic t_ud();
    for (int k = 0; k < 10; k++) begin
      base();
      case (k)
        0: nc.protection_enable_bit = 1'b0;
        1: nc.virtual8086_flag = 1'b1;
        2: nc.system_management_mode = 1'b1;
        3: nc.base_enclave_feature_bit = 1'b0;
        4: ni.pfx_lock = 1'b1;
        5: ni.pfx_osize = 1'b1;
        6: ni.pfx_rep = 1'b1;
        7: ni.pfx_vex = 1'b1;
        8: nc.current_privilege_level = 2'h3;
        default: ni.b2 = 8'hD7;
      endcase
      run(RES_UD);
    end
    nc.transactional_execution = 1'b1;
    run(RES_TSX_ABORT);
  endtask : t_ud
  task automatic t_gp();
    for (int k = 0; k < 9; k++) begin
      base();
      case (k)
        0: nc.feature_lock_register = 8'h02;
        1: nc.feature_lock_register = 8'h01;
        2: ni.rax = {32'h0, LEAF_COUNT};
        3: nc.paging_enable_bit = 1'b0;
        4: {nc.cs_long, nc.ds_expand_down} = 2'b01;
        5: nc.ds_expand_down = 1'b1;
        6: ni.rax = 64'hFFFFFFFF_00000012;
        7: {ni.pfx_seg, ni.pfx_asize, ni.pfx_rex} = 3'b111;
        default: nc.long_mode_active = 1'b0;
      endcase
      run(k < 5 ? RES_GP : RES_DISPATCH);
      if (k < 5) chk("code", done.code, ERR_ZERO);
      if (k > 6) chk("wide", done.wide, k == 7);
      if (k == 6) chk("leaf_hi", done.leaf, 32'h00000012);
    end
    chk("leaf", done.leaf, 0);
  endtask : t_gp
  task automatic t_exit();
    base();
    {nc.virtualization_operation, nc.exiting_control} = 2'b11;
    nc.exit_bitmap = 64'h80000000_00000020;
    ni.rax = 64'h05;
    run(RES_VMEXIT);
    ni.rax = 64'h46;
    run(RES_VMEXIT);
    ni.rax = 64'h3E;
    run(RES_GP);
    nc.current_privilege_level = 2'h1;
    run(RES_UD);
  endtask : t_exit
  task automatic t_track();
    base();
    ni.rax = {32'h0, LEAF_TRACK};
    run(RES_DISPATCH);
    chk("hold", track_hold, 1);
    @(posedge pclk) track_busy <= 1'b1;
    ni.rax = {32'h0, LEAF_TRACKC};
    run(RES_CONFLICT);
    nc.virtualization_operation = 1'b1;
    run(RES_CONFLICT);
    chk("qual", done.code, QUAL_TRK_CONFLICT);
    ni.rax = 64'h00;
    run(RES_DISPATCH);
    apb(1'b1, REG_CTRL, 32'h1);
    ni.rax = {32'h0, LEAF_TRACK};
    run(RES_DISPATCH);
  endtask : t_track
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", q, CTRL_RST);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", e, 1);
    t_ud();
    t_gp();
    t_exit();
    t_track();
    apb(1'b0, REG_COUNT, 32'h0);
    chk("count", q, nd);
    apb(1'b0, REG_LEAF, 32'h0);
    chk("leaf_reg", q, LEAF_TRACK);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", q, {11'h000, ERR_ZERO, 1'b1, RES_DISPATCH});
    summarize();
  end
endmodule : privileged_enclave_call_checker_bench
